// >>> logic/utx_defines.vh
`ifndef UTX_DEFINES_VH
`define UTX_DEFINES_VH

// ----------------------------------------
// Check bit kinds
// ----------------------------------------
`define UTX_CHK_EVEN      3'h0
`define UTX_CHK_ODD       3'h1
`define UTX_CHK_SPACE     3'h2
`define UTX_CHK_MARK      3'h3
`define UTX_CHK_NONE      3'h4

// ----------------------------------------
// Channel test modes
// ----------------------------------------
`define UTX_CH_NORMAL     2'h0
`define UTX_CH_ECHO       2'h1
`define UTX_CH_LOCAL      2'h2
`define UTX_CH_REMOTE     2'h3

// ----------------------------------------
// Reset values and bit timing
// ----------------------------------------
`define UTX_DIV_RST       5'h13
`define UTX_DUTY_RST      3'h0
`define UTX_OVERSAMPLE    5'h10
`define UTX_DATA_BITS     4'h8
`define UTX_DIV_BASE      6'h08
`define UTX_MOD_PRESCALE  4'h8
`define UTX_DMA_BASE      12'h100

`endif

// >>> logic/utx_modulator.v
`timescale 1ns/1ps
`default_nettype none

`include "utx_defines.vh"

module utx_modulator
(
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Optical source clock enable
    input  wire       src_tick,
    // Settings
    input  wire       enable,
    input  wire [4:0] modulation_divider,
    input  wire [2:0] modulation_duty_sel,
    // Modulation clock
    output reg        mod_clk_r
);

    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    // One period spans 8 * (div + 8) source ticks; high time shrinks by 1/16 per step
    wire [9:0] period_w = {1'b0, (modulation_divider + `UTX_DIV_BASE), 3'h0};
    wire [13:0] high_full = period_w * (5'h08 - {2'h0, modulation_duty_sel});
    wire [9:0] high_w = high_full[13:4];

    reg  [9:0] cnt_r;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r     <= 10'h000;
            mod_clk_r <= 1'b0;
        end
        else if (!enable)
        begin
            cnt_r     <= 10'h000;
            mod_clk_r <= 1'b0;
        end
        else if (src_tick)
        begin
            if (cnt_r >= period_w - 10'h001)
                cnt_r <= 10'h000;
            else
                cnt_r <= cnt_r + 10'h001;
            mod_clk_r <= (cnt_r < high_w);
        end
    end

endmodule // utx_modulator

`default_nettype wire

// >>> logic/utx_top.v
`timescale 1ns/1ps
`default_nettype none

`include "utx_defines.vh"

// What this block does
// - Filter on: receive line is majority of three 16x samples; off at reset.
// - Transmitter off at reset; after enable waits for a held character.
// - Disable stops at once if idle, else finishes shift and held characters.
// - Transmitter reset stops at once and drops everything.
// - Frame: start 0, eight data bits LSB first, optional parity, stop 1.
// - Parity is even, odd, or forced space or mark.
// - Parity kind: 0 even, 1 odd, 2 zero, 3 one, 4 none.
// - Holding-free set on enable, cleared on write, set on move to shifter.
// - All-drained rises after final stop bit with both registers empty.
// - Optical on switches receive pad to analog and enables comparator.
// - Optical: output 0 sends modulation clock, 1 sends steady high.
// - Modulation clock is source clock over 8 times divider plus eight.
// - Default divider gives 38 kHz from an 8192 kHz source.
// - Modulated output idles high; invert bit flips its polarity.
// - Duty programmable 50 down to 6.25 percent, 50 by default.
// - Duty field 0 gives 50 percent, each step removes 6.25 percent.
// - Receive ready and holding-free raise read and write DMA requests.
// - DMA channel registers sit from offset 0x100 in the port space.
// - Echo mode forwards receive pin to transmit pin; transmitter still runs.
// - Local loopback feeds transmitter to receiver; transmit pin held high.
// - Remote loopback ties receive pin to transmit pin; tx and rx idle.
module utx_top
#(
    // Divider reset value; the live setting arrives on modulation_divider
    parameter [4:0] DIV_RST = `UTX_DIV_RST
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Rate enables
    input  wire        os16_tick,
    input  wire        optical_source_tick,
    // Commands
    input  wire        tx_enable_cmd,
    input  wire        tx_disable_cmd,
    input  wire        tx_reset_cmd,
    // Holding register write
    input  wire        tx_holding_wr,
    input  wire [7:0]  tx_holding_data,
    // Mode configuration
    input  wire        filter_on,
    input  wire [2:0]  check_bit_kind,
    input  wire [1:0]  channel_test_sel,
    input  wire        optical_on,
    input  wire        modulated_out_invert,
    input  wire [2:0]  modulation_duty_sel,
    input  wire [4:0]  modulation_divider,
    input  wire [2:0]  comparator_threshold_sel,
    // Receiver hook
    input  wire        rx_char_ready,
    // Pins
    input  wire        serial_in_pin,
    output reg         serial_out_pin,
    output reg         rx_pad_analog,
    output reg         rx_comparator_en,
    output reg  [2:0]  comparator_ref_sel,
    // Receiver side
    output reg         rx_line,
    output reg         rx_disable_test,
    // Status and DMA
    output reg         tx_holding_free,
    output reg         tx_all_drained,
    output reg         tx_enabled,
    output wire        dma_tx_req,
    output wire        dma_rx_req,
    output wire [11:0] dma_reg_base
);

    // ----------------------------------------
    // Transmit state machine
    // ----------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;

    reg  [1:0]  state_r;
    reg         en_r;
    reg         stop_pend_r;
    reg         hold_full_r;
    reg  [7:0]  hold_r;
    reg  [10:0] shift_r;
    reg  [3:0]  bits_left_r;
    reg  [3:0]  os_cnt_r;
    reg         tx_out_r;
    reg         drained_r;
    reg         started_r;

    // ----------------------------------------
    // Parity
    // ----------------------------------------
    reg parity_bit;
    always @*
    begin
        case (check_bit_kind)
            `UTX_CHK_EVEN:  parity_bit = ^hold_r;
            `UTX_CHK_ODD:   parity_bit = ~(^hold_r);
            `UTX_CHK_SPACE: parity_bit = 1'b0;
            `UTX_CHK_MARK:  parity_bit = 1'b1;
            default:        parity_bit = 1'b1;
        endcase
    end

    wire has_parity = (check_bit_kind < `UTX_CHK_NONE);
    // Remote loopback holds the transmitter still
    wire run_ok     = en_r && (channel_test_sel != `UTX_CH_REMOTE);
    wire bit_end    = os16_tick && (os_cnt_r == 4'hF);
    // A write taken this cycle must block a stop and keep the drained flag low
    wire hold_wr_ok = tx_holding_wr && en_r && !hold_full_r;
    wire en_cmd     = tx_enable_cmd && !tx_disable_cmd;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r     <= ST_IDLE;
            en_r        <= 1'b0;
            stop_pend_r <= 1'b0;
            hold_full_r <= 1'b0;
            hold_r      <= 8'h00;
            shift_r     <= 11'h7FF;
            bits_left_r <= 4'h0;
            os_cnt_r    <= 4'h0;
            tx_out_r    <= 1'b1;
            drained_r   <= 1'b0;
            started_r   <= 1'b0;
        end
        else if (tx_reset_cmd)
        begin
            // Abort wins over any other command in the same cycle
            state_r     <= ST_IDLE;
            en_r        <= 1'b0;
            stop_pend_r <= 1'b0;
            hold_full_r <= 1'b0;
            tx_out_r    <= 1'b1;
            os_cnt_r    <= 4'h0;
            drained_r   <= 1'b0;
            started_r   <= 1'b0;
        end
        else
        begin
            if (en_cmd)
            begin
                en_r        <= 1'b1;
                stop_pend_r <= 1'b0;
                if (!started_r)
                    drained_r <= 1'b1;
            end
            else if (tx_disable_cmd && en_r)
            begin
                if (state_r == ST_IDLE && !hold_full_r && !hold_wr_ok)
                    en_r <= 1'b0;
                else
                    stop_pend_r <= 1'b1;
            end
            if (hold_wr_ok)
            begin
                hold_r      <= tx_holding_data;
                hold_full_r <= 1'b1;
                drained_r   <= 1'b0;
                started_r   <= 1'b1;
            end
            case (state_r)
                ST_IDLE:
                begin
                    tx_out_r <= 1'b1;
                    if (hold_full_r && run_ok)
                    begin
                        // Load stop, parity, data, start; LSB shifts first
                        shift_r     <= {1'b1, parity_bit, hold_r, 1'b0};
                        bits_left_r <= has_parity ? 4'hB : 4'hA;
                        hold_full_r <= 1'b0;
                        os_cnt_r    <= 4'h0;
                        state_r     <= ST_SHIFT;
                    end
                    else if (stop_pend_r && !hold_full_r && !hold_wr_ok && !en_cmd)
                    begin
                        en_r        <= 1'b0;
                        stop_pend_r <= 1'b0;
                    end
                end
                ST_SHIFT:
                begin
                    tx_out_r <= shift_r[0];
                    if (os16_tick)
                        os_cnt_r <= os_cnt_r + 4'h1;
                    if (bit_end)
                    begin
                        if (bits_left_r == 4'h2 && !has_parity)
                            shift_r <= {1'b1, 1'b1, shift_r[10:2]};
                        else
                            shift_r <= {1'b1, shift_r[10:1]};
                        bits_left_r <= bits_left_r - 4'h1;
                        if (bits_left_r == 4'h1)
                        begin
                            state_r  <= ST_IDLE;
                            tx_out_r <= 1'b1;
                            if (!hold_full_r && !hold_wr_ok)
                                drained_r <= 1'b1;
                        end
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receive filter
    // ----------------------------------------
    reg  [2:0] rx_samp_r;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rx_samp_r <= 3'h7;
        else if (os16_tick)
            rx_samp_r <= {rx_samp_r[1:0], serial_in_pin};
    end
    wire rx_vote = (rx_samp_r[0] & rx_samp_r[1]) | (rx_samp_r[1] & rx_samp_r[2])
                 | (rx_samp_r[0] & rx_samp_r[2]);
    wire rx_pin_val = filter_on ? rx_vote : serial_in_pin;

    // ----------------------------------------
    // Optical modulator
    // ----------------------------------------
    wire mod_clk;
    utx_modulator u_mod
    (
        .clk                 (clk),
        .rstn                (rstn),
        .src_tick            (optical_source_tick),
        .enable              (optical_on),
        .modulation_divider  (modulation_divider),
        .modulation_duty_sel (modulation_duty_sel),
        .mod_clk_r           (mod_clk)
    );

    // ----------------------------------------
    // Pin muxing and outputs
    // ----------------------------------------
    reg line_nxt;
    always @*
    begin
        case (channel_test_sel)
            `UTX_CH_ECHO:   line_nxt = rx_pin_val;
            `UTX_CH_LOCAL:  line_nxt = 1'b1;
            `UTX_CH_REMOTE: line_nxt = serial_in_pin;
            default:        line_nxt = tx_out_r;
        endcase
    end

    // Output 0 carries the carrier; idle level 1 unless inverted
    wire opt_line = (line_nxt ? 1'b1 : ~mod_clk) ^ modulated_out_invert;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_out_pin     <= 1'b1;
            rx_pad_analog      <= 1'b0;
            rx_comparator_en   <= 1'b0;
            comparator_ref_sel <= 3'h0;
            rx_line            <= 1'b1;
            rx_disable_test    <= 1'b0;
            tx_holding_free    <= 1'b0;
            tx_all_drained     <= 1'b0;
            tx_enabled         <= 1'b0;
        end
        else
        begin
            serial_out_pin     <= optical_on ? opt_line : line_nxt;
            rx_pad_analog      <= optical_on;
            rx_comparator_en   <= optical_on;
            comparator_ref_sel <= comparator_threshold_sel;
            rx_line            <= (channel_test_sel == `UTX_CH_LOCAL) ? tx_out_r : rx_pin_val;
            rx_disable_test    <= (channel_test_sel == `UTX_CH_REMOTE);
            tx_holding_free    <= en_r && !hold_full_r;
            tx_all_drained     <= en_r && drained_r;
            tx_enabled         <= en_r;
        end
    end

    assign dma_tx_req   = tx_holding_free;
    assign dma_rx_req   = rx_char_ready;
    assign dma_reg_base = `UTX_DMA_BASE;

endmodule // utx_top

`default_nettype wire

// >>> tb/test_utx_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_utx_top;
    logic        clk = 0, rstn = 0, os16_tick = 0, optical_source_tick, serial_in_pin;
    logic        tx_enable_cmd, tx_disable_cmd, tx_reset_cmd, tx_holding_wr, filter_on;
    logic        optical_on, modulated_out_invert, rx_char_ready;
    logic [7:0]  tx_holding_data;
    logic [2:0]  check_bit_kind, modulation_duty_sel, comparator_threshold_sel;
    logic [1:0]  channel_test_sel;
    logic [4:0]  modulation_divider;
    wire         serial_out_pin, rx_pad_analog, rx_comparator_en, rx_line, rx_disable_test;
    wire         tx_holding_free, tx_all_drained, tx_enabled, dma_tx_req, dma_rx_req;
    wire [2:0]   comparator_ref_sel;
    wire [11:0]  dma_reg_base;
    int          error_cnt = 0, num_checks = 0, cycles = 0, tc = 0, osd = 2;
    logic [19:0] f;
    utx_top uut (.*);
    utx_partner u_far (.clk(clk), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin), .optical_source_tick(optical_source_tick));
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        #1;
        tc = (tc + 1) % osd;
        os16_tick = (tc == 0);
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            stop_test;
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input logic [2:0] c);
        {tx_reset_cmd, tx_disable_cmd, tx_enable_cmd} = c;
        cyc(1);
        {tx_reset_cmd, tx_disable_cmd, tx_enable_cmd} = 3'h0;
    endtask
    task wr(input logic [7:0] d);
        tx_holding_data = d;
        tx_holding_wr = 1;
        cyc(1);
        tx_holding_wr = 0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task t_frames;
        logic [7:0] d;
        logic       e;
        chk({tx_enabled, tx_holding_free}, 2'h0);
        cmd(3'h1);
        cyc(2);
        chk({tx_holding_free, tx_all_drained}, 2'h3);
        for (int k = 0; k < 5; k++)
        begin
            d = 8'h5A ^ 8'(k);
            check_bit_kind = 3'(k);
            e = (k == 0) ? ^d : (k == 1) ? ~^d : (k != 2);
            fork
                u_far.get((k == 4) ? 20 : 11, f);
                begin
                    wr(d);
                    if (k == 4)
                    begin
                        cyc(4);
                        wr(~d);
                        cyc(2);
                        chk(tx_holding_free, 0);
                    end
                end
            join
            chk(f[9:0], {e, d, 1'b0});
            if (k == 4)
                chk(f[19:10], {1'b1, ~d, 1'b0});
        end
        cyc(40);
        chk(tx_all_drained, 1);
    endtask
    task t_disable;
        fork
            u_far.get(20, f);
            begin
                wr(8'hC3);
                cyc(4);
                wr(8'h18);
                cmd(3'h2);
            end
        join
        chk({f[18:10], f[8:0]}, {8'h18, 1'b0, 8'hC3, 1'b0});
        cyc(40);
        chk(tx_enabled, 0);
    endtask
    task t_reset;
        cmd(3'h1);
        cyc(2);
        wr(8'h00);
        cyc(4);
        // A pending second character must be dropped as well
        wr(8'h00);
        cyc(100);
        cmd(3'h4);
        cyc(300);
        chk({tx_enabled, tx_holding_free, serial_out_pin}, 3'h1);
    endtask
    task t_modes;
        filter_on = 1;
        // One low cycle gives at most one low sample, which the vote must hide
        u_far.serial_in_pin = 0;
        repeat (8)
        begin
            cyc(1);
            chk(rx_line, 1);
            u_far.serial_in_pin = 1;
        end
        for (int m = 1; m < 4; m += 2)
        begin
            channel_test_sel = 2'(m);
            cyc(4);
            fork
                u_far.send(8'h96);
                u_far.get(10, f);
            join
            chk({rx_disable_test, f[9:0]}, {m == 3, 10'h32C});
        end
        channel_test_sel = 2'h2;
        cmd(3'h1);
        cyc(2);
        wr(8'hF0);
        for (int i = 0; i < 40 && rx_line !== 1'b0; i++)
            cyc(1);
        chk({rx_line, serial_out_pin}, 2'h1);
        cyc(400);
        channel_test_sel = 2'h0;
        rx_char_ready = 1;
        cyc(1);
        chk({dma_rx_req, dma_tx_req, dma_reg_base}, 14'h3100);
        rx_char_ready = 0;
        cyc(1);
        chk(dma_rx_req, 0);
    endtask
    task t_optical;
        int h;
        cmd(3'h2);
        optical_on = 1;
        cyc(4);
        chk({rx_pad_analog, rx_comparator_en, serial_out_pin}, 3'h7);
        chk({comparator_ref_sel, tx_enabled}, 4'h8);
        // Reset divider must give 38 kHz from an 8192 kHz source, to the nearest kHz
        chk(20'((8192 + 4 * (uut.DIV_RST + 8)) / (8 * (uut.DIV_RST + 8))), 20'h26);
        modulated_out_invert = 1;
        cyc(4);
        chk(serial_out_pin, 0);
        modulated_out_invert = 0;
        osd = 25;
        cmd(3'h1);
        cyc(2);
        // One carrier period is 8 * 8 * 25 = 1600 cycles, one bit 400
        for (int k = 0; k < 8; k += 7)
        begin
            modulation_duty_sel = 3'(k);
            wr(8'h00);
            for (int i = 0; i < 2000 && serial_out_pin; i++)
                cyc(1);
            h = 0;
            repeat (1600)
            begin
                cyc(1);
                h += serial_out_pin;
            end
            chk(20'(h), 20'(800 + 100 * k));
            cyc(3000);
        end
    endtask
    initial
    begin
        {tx_enable_cmd, tx_disable_cmd, tx_reset_cmd, tx_holding_wr, filter_on} = '0;
        {optical_on, modulated_out_invert, rx_char_ready, tx_holding_data} = '0;
        {check_bit_kind, modulation_duty_sel, modulation_divider, channel_test_sel} = '0;
        comparator_threshold_sel = 3'h4;
        repeat (10) @(posedge clk);
        #1 rstn = 1;
        cyc(1);
        t_frames;
        $display("frames done");
        t_disable;
        $display("disable done");
        t_reset;
        $display("reset done");
        t_modes;
        $display("modes done");
        t_optical;
        $display("optical done");
        stop_test;
    end
endmodule // test_utx_top
`default_nettype wire

// >>> tb/utx_partner.sv
`timescale 1ns/1ps
`default_nettype none
module utx_partner
#(
    parameter int BIT = 32,
    parameter int SRC = 25
)
(
    // Clock and line
    input  wire logic clk,
    input  wire logic serial_out_pin,
    output var logic  serial_in_pin,
    output var logic  optical_source_tick
);
    int n = 0;
    initial serial_in_pin = 1'b1;
    initial optical_source_tick = 1'b0;
    // 200 MHz over 25 gives an 8000 kHz source
    always @(posedge clk)
    begin
        #1;
        n = (n + 1) % SRC;
        optical_source_tick = (n == 0);
    end
    task send(input logic [7:0] d);
        for (int i = 0; i < 10; i++)
        begin
            serial_in_pin = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
            repeat (BIT) @(posedge clk);
            #1;
        end
    endtask
    // Samples mid-bit; a missed start edge hangs until the bench timeout
    task get(input int cnt, output logic [19:0] f);
        f = '1;
        @(negedge serial_out_pin);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < cnt; i++)
        begin
            f[i] = serial_out_pin;
            repeat (BIT) @(posedge clk);
        end
    endtask
endmodule // utx_partner
`default_nettype wire

// >>> tb/utx_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module utx_props
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Controls
    input wire logic        tx_enable_cmd,
    input wire logic        tx_disable_cmd,
    input wire logic        tx_reset_cmd,
    input wire logic [1:0]  channel_test_sel,
    input wire logic        optical_on,
    input wire logic        modulated_out_invert,
    // Outputs
    input wire logic        serial_out_pin,
    input wire logic        rx_pad_analog,
    input wire logic        rx_comparator_en,
    input wire logic        rx_disable_test,
    input wire logic        tx_holding_free,
    input wire logic        tx_enabled,
    input wire logic        dma_tx_req,
    input wire logic [11:0] dma_reg_base
);
    // ------
    // Checks
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_start;
        $fell(serial_out_pin) && channel_test_sel == 2'h0 && !optical_on;
    endsequence
    sequence s_low8;
        !serial_out_pin [*8];
    endsequence
    AST_DMA_TX: assert property (dma_tx_req == tx_holding_free)
        else $error("dma tx request wrong");
    AST_DMA_BASE: assert property (dma_reg_base == 12'h100)
        else $error("dma base wrong");
    AST_PAD: assert property ($rose(optical_on) |=> rx_pad_analog && rx_comparator_en)
        else $error("pad not analog");
    AST_ENABLE: assert property (tx_enable_cmd && !tx_disable_cmd && !tx_reset_cmd |-> ##2 tx_enabled)
        else $error("enable lost");
    AST_RESET: assert property (tx_reset_cmd |-> ##2 !tx_enabled && !tx_holding_free)
        else $error("reset ignored");
    AST_START: assert property (s_start |-> s_low8)
        else $error("start bit short");
    AST_LOCAL: assert property ((channel_test_sel == 2'h2 && !optical_on) [*2] |-> serial_out_pin)
        else $error("pin not idle");
    AST_REMOTE: assert property ((channel_test_sel == 2'h3) [*2] |-> rx_disable_test)
        else $error("receiver not idled");
    AST_OPT_IDLE: assert property ((optical_on && !tx_enabled && channel_test_sel == 2'h0
        && $stable(modulated_out_invert)) [*3] |-> serial_out_pin != modulated_out_invert)
        else $error("optical idle level wrong");
endmodule // utx_props
bind utx_top utx_props u_props (.*);
`default_nettype wire
